// file: core/pbi_pkg.sv
// shared constants and types for the bus side interface
package pbi_pkg;
  localparam int          AD_W        = 32;
  localparam int          CBE_W       = 4;
  localparam logic [3:0]  CMD_IO_RD   = 4'h2;
  localparam logic [3:0]  CMD_IO_WR   = 4'h3;
  localparam logic [3:0]  CMD_MEM_RD  = 4'h6;
  localparam logic [3:0]  CMD_MEM_WR  = 4'h7;
  localparam logic [3:0]  CMD_CFG_RD  = 4'ha;
  localparam logic [3:0]  CMD_CFG_WR  = 4'hb;
  localparam logic [1:0]  ADDR_LOW_Z  = 2'h0;
  localparam logic [31:0] REG_BASE    = 32'h0000_0800;
  localparam logic [31:0] REG_MASK    = 32'hffff_ffc0;
  localparam logic [31:0] DOWN_BASE   = 32'h0000_0000;
  localparam logic [31:0] DOWN_MASK   = 32'hffff_f000;
  localparam int          SUB_WAIT    = 3;
  localparam logic [1:0]  SUB_WAIT_C  = 2'h3;
  localparam int          MREG_N      = 16;
  localparam int          MREG_IW     = 4;
  typedef enum logic [2:0] {PBI_IDLE, PBI_ADDR, PBI_DATA, PBI_TURN} pbi_ist_t;
  typedef enum logic [2:0] {PBT_IDLE, PBT_DEC, PBT_DATA, PBT_TURN} pbi_tst_t;
endpackage

// file: core/pbi_bus_if.sv
// shared bus wires between the device end and the far agent end
`timescale 1ns/100ps
`default_nettype none
interface pbi_bus_if;
  import pbi_pkg::*;
  logic [31:0] ad_dev_o;
  logic [31:0] ad_far_o;
  logic        ad_dev_oe_n;
  logic        ad_far_oe_n;
  logic [3:0]  cbe_n_dev_o;
  logic [3:0]  cbe_n_far_o;
  logic        cbe_dev_oe_n;
  logic        cbe_far_oe_n;
  logic        frame_n_dev_o;
  logic        frame_n_far_o;
  logic        frame_dev_oe_n;
  logic        frame_far_oe_n;
  logic        irdy_n_dev_o;
  logic        irdy_n_far_o;
  logic        irdy_dev_oe_n;
  logic        irdy_far_oe_n;
  logic        trdy_n_dev_o;
  logic        trdy_n_far_o;
  logic        trdy_dev_oe_n;
  logic        trdy_far_oe_n;
  logic        devsel_n_dev_o;
  logic        devsel_n_far_o;
  logic        devsel_dev_oe_n;
  logic        devsel_far_oe_n;
  logic        par_dev_o;
  logic        par_dev_oe_n;
  logic        clkrun_n_dev_o;
  logic        clkrun_dev_oe_n;
  logic        clkrun_n_far_o;
  logic        clkrun_far_oe_n;
  logic        idsel;
  logic        bus_reset_out_n;
  logic [31:0] ad;
  logic [3:0]  cbe_n;
  logic        frame_n;
  logic        irdy_n;
  logic        trdy_n;
  logic        devsel_n;
  logic        clkrun_n;
  // resolved wire levels, pulled up when nobody drives
  assign ad       = !ad_dev_oe_n ? ad_dev_o : (!ad_far_oe_n ? ad_far_o : 32'hffff_ffff);
  assign cbe_n    = !cbe_dev_oe_n ? cbe_n_dev_o : (!cbe_far_oe_n ? cbe_n_far_o : 4'hf);
  assign frame_n  = !frame_dev_oe_n ? frame_n_dev_o : (!frame_far_oe_n ? frame_n_far_o : 1'b1);
  assign irdy_n   = !irdy_dev_oe_n ? irdy_n_dev_o : (!irdy_far_oe_n ? irdy_n_far_o : 1'b1);
  assign trdy_n   = !trdy_dev_oe_n ? trdy_n_dev_o : (!trdy_far_oe_n ? trdy_n_far_o : 1'b1);
  assign devsel_n = !devsel_dev_oe_n ? devsel_n_dev_o :
                    (!devsel_far_oe_n ? devsel_n_far_o : 1'b1);
  assign clkrun_n = (!clkrun_dev_oe_n && !clkrun_n_dev_o) ||
                    (!clkrun_far_oe_n && !clkrun_n_far_o) ? 1'b0 : 1'b1;
  modport dev (
    output ad_dev_o, ad_dev_oe_n, cbe_n_dev_o, cbe_dev_oe_n, frame_n_dev_o, frame_dev_oe_n,
    output irdy_n_dev_o, irdy_dev_oe_n, trdy_n_dev_o, trdy_dev_oe_n,
    output devsel_n_dev_o, devsel_dev_oe_n, par_dev_o, par_dev_oe_n,
    output clkrun_n_dev_o, clkrun_dev_oe_n, bus_reset_out_n,
    input  ad, cbe_n, frame_n, irdy_n, trdy_n, devsel_n, clkrun_n, idsel
  );
  modport far (
    output ad_far_o, ad_far_oe_n, cbe_n_far_o, cbe_far_oe_n, frame_n_far_o, frame_far_oe_n,
    output irdy_n_far_o, irdy_far_oe_n, trdy_n_far_o, trdy_far_oe_n,
    output devsel_n_far_o, devsel_far_oe_n, clkrun_n_far_o, clkrun_far_oe_n, idsel,
    input  ad, cbe_n, frame_n, irdy_n, trdy_n, devsel_n, clkrun_n, bus_reset_out_n
  );
endinterface
`default_nettype wire

// file: core/pbi_par_gen.sv
// even parity over the 36 lanes, presented one clock later
`timescale 1ns/100ps
`default_nettype none
module pbi_par_gen
  import pbi_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [31:0] ad_i,
  input  wire logic [3:0]  cbe_n_i,
  input  wire logic        drive_i,
  output logic             par_o,
  output logic             par_oe_n_o
);
  logic par_ff;
  logic nxt_par;
  logic oe_n_ff;
  logic nxt_oe_n;
  always_comb
  begin
    nxt_par  = ^{ad_i, cbe_n_i};
    nxt_oe_n = !drive_i;
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      par_ff  <= 1'b0;
      oe_n_ff <= 1'b1;
    end
    else
    begin
      par_ff  <= nxt_par;
      oe_n_ff <= nxt_oe_n;
    end
  end
  assign par_o      = par_ff;
  assign par_oe_n_o = oe_n_ff;
endmodule
`default_nettype wire

// file: core/pbi_dev_end.sv
// device end: initiator and target on the shared bus
`timescale 1ns/100ps
`default_nettype none
module pbi_dev_end
  import pbi_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  pbi_bus_if.dev           bus,
  input  wire logic        suspend_i,
  input  wire logic        clk_stop_req_i,
  output logic             clk_stop_ok_o,
  input  wire logic        subtractive_en_i,
  input  wire logic        req_valid_i,
  output logic             req_ready_o,
  input  wire logic [31:0] req_addr_i,
  input  wire logic [3:0]  req_cmd_i,
  input  wire logic [31:0] req_wdata_i,
  input  wire logic [3:0]  req_be_i,
  output logic             rsp_valid_o,
  output logic [31:0]      rsp_rdata_o,
  output logic             rsp_abort_o
);
  // ==========================================
  // input synchronisers
  logic [7:0] s1_ff;
  logic [7:0] s2_ff;
  logic       frame_s;
  logic       irdy_s;
  logic       trdy_s;
  logic       devsel_s;
  logic       idsel_s;
  logic       clkrun_s;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s1_ff <= 8'hff;
      s2_ff <= 8'hff;
    end
    else
    begin
      s1_ff <= {2'h3, ~bus.idsel, bus.clkrun_n, bus.devsel_n, bus.trdy_n, bus.irdy_n, bus.frame_n};
      s2_ff <= s1_ff;
    end
  end
  assign frame_s  = !s2_ff[0];
  assign irdy_s   = !s2_ff[1];
  assign trdy_s   = !s2_ff[2];
  assign devsel_s = !s2_ff[3];
  assign clkrun_s = !s2_ff[4];
  assign idsel_s  = !s2_ff[5];
  logic [31:0] ad1_ff;
  logic [31:0] ad2_ff;
  logic [3:0]  cb1_ff;
  logic [3:0]  cb2_ff;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ad1_ff <= 32'h0;
      ad2_ff <= 32'h0;
      cb1_ff <= 4'hf;
      cb2_ff <= 4'hf;
    end
    else
    begin
      ad1_ff <= bus.ad;
      ad2_ff <= ad1_ff;
      cb1_ff <= bus.cbe_n;
      cb2_ff <= cb1_ff;
    end
  end
  // ==========================================
  // bus reset and clock run
  logic rst_out_ff;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rst_out_ff <= 1'b0;
    else
      rst_out_ff <= 1'b1;
  end
  assign bus.bus_reset_out_n = rst_out_ff;
  always_comb
  begin
    bus.clkrun_dev_oe_n = 1'b0;
    if (!rst_out_ff)
      bus.clkrun_n_dev_o = 1'b0;
    else if (suspend_i)
      bus.clkrun_n_dev_o = 1'b1;
    else
      bus.clkrun_n_dev_o = clk_stop_req_i ? 1'b1 : 1'b0;
  end
  assign clk_stop_ok_o = clk_stop_req_i && !clkrun_s;
  // ==========================================
  // initiator
  pbi_ist_t    ist_ff, nxt_ist;
  pbi_tst_t    tst_ff, nxt_tst;
  logic [31:0] iad_ff, nxt_iad;
  logic [3:0]  icb_ff, nxt_icb;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        rv_ff, nxt_rv;
  logic        ab_ff, nxt_ab;
  logic [1:0]  iw_ff, nxt_iw;
  logic        iwr;
  assign iwr = req_cmd_i[0];
  always_comb
  begin
    nxt_ist   = ist_ff;
    nxt_iad   = iad_ff;
    nxt_icb   = icb_ff;
    nxt_rdata = rdata_ff;
    nxt_rv    = 1'b0;
    nxt_ab    = ab_ff;
    nxt_iw    = iw_ff;
    case (ist_ff)
      PBI_IDLE:
        if (req_valid_i && !frame_s && !suspend_i && tst_ff == PBT_IDLE)
        begin
          nxt_iad = {req_addr_i[31:2], ADDR_LOW_Z};
          nxt_icb = req_cmd_i;
          nxt_ist = PBI_ADDR;
          nxt_iw  = 2'h0;
        end
      PBI_ADDR:
      begin
        nxt_iad = iwr ? req_wdata_i : iad_ff;
        nxt_icb = ~req_be_i;
        nxt_ist = PBI_DATA;
      end
      PBI_DATA:
        if (trdy_s && irdy_s)
        begin
          nxt_rdata = ad2_ff;
          nxt_rv    = 1'b1;
          nxt_ab    = 1'b0;
          nxt_ist   = PBI_TURN;
        end
        else if (!devsel_s && iw_ff == SUB_WAIT_C)
        begin
          nxt_rv  = 1'b1;
          nxt_ab  = 1'b1;
          nxt_ist = PBI_TURN;
        end
        else if (!devsel_s)
          nxt_iw = iw_ff + 2'h1;
      default:
        nxt_ist = PBI_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ist_ff   <= PBI_IDLE;
      iad_ff   <= 32'h0;
      icb_ff   <= 4'hf;
      rdata_ff <= 32'h0;
      rv_ff    <= 1'b0;
      ab_ff    <= 1'b0;
      iw_ff    <= 2'h0;
    end
    else
    begin
      ist_ff   <= nxt_ist;
      iad_ff   <= nxt_iad;
      icb_ff   <= nxt_icb;
      rdata_ff <= nxt_rdata;
      rv_ff    <= nxt_rv;
      ab_ff    <= nxt_ab;
      iw_ff    <= nxt_iw;
    end
  end
  assign req_ready_o = ist_ff == PBI_IDLE && !frame_s && !suspend_i && tst_ff == PBT_IDLE;
  assign rsp_valid_o = rv_ff;
  assign rsp_rdata_o = rdata_ff;
  assign rsp_abort_o = ab_ff;
  logic i_drv;
  logic i_adrv;
  assign i_drv  = rst_out_ff && !suspend_i && (ist_ff == PBI_ADDR || ist_ff == PBI_DATA);
  assign i_adrv = i_drv && (ist_ff == PBI_ADDR || iwr);
  assign bus.frame_dev_oe_n = !i_drv;
  assign bus.frame_n_dev_o  = !(ist_ff == PBI_ADDR);
  assign bus.irdy_dev_oe_n  = !(i_drv && ist_ff == PBI_DATA);
  assign bus.irdy_n_dev_o   = 1'b0;
  // ==========================================
  // target
  logic        twr_ff, nxt_twr;
  logic [1:0]  tw_ff, nxt_tw;
  logic [3:0]  tidx_ff, nxt_tidx;
  logic        dsel_ff, nxt_dsel;
  logic [31:0] mreg_ff [MREG_N];
  logic        t_hit;
  logic        t_cfg;
  logic        t_down;
  assign t_cfg  = idsel_s && (cb2_ff == CMD_CFG_RD || cb2_ff == CMD_CFG_WR);
  assign t_hit  = (ad2_ff & REG_MASK) == REG_BASE;
  assign t_down = (ad2_ff & DOWN_MASK) == DOWN_BASE;
  always_comb
  begin
    nxt_tst  = tst_ff;
    nxt_twr  = twr_ff;
    nxt_tw   = tw_ff;
    nxt_tidx = tidx_ff;
    nxt_dsel = dsel_ff;
    case (tst_ff)
      PBT_IDLE:
        if (frame_s && ist_ff == PBI_IDLE)
        begin
          nxt_twr  = cb2_ff[0];
          nxt_tidx = ad2_ff[5:2];
          nxt_tw   = 2'h0;
          if (t_cfg || t_hit || t_down)
          begin
            nxt_dsel = 1'b1;
            nxt_tst  = PBT_DATA;
          end
          else if (subtractive_en_i)
            nxt_tst = PBT_DEC;
        end
      PBT_DEC:
        if (devsel_s)
          nxt_tst = PBT_TURN;
        else if (tw_ff == SUB_WAIT_C)
        begin
          nxt_dsel = 1'b1;
          nxt_tst  = PBT_DATA;
        end
        else
          nxt_tw = tw_ff + 2'h1;
      PBT_DATA:
        if (irdy_s)
        begin
          nxt_dsel = 1'b0;
          nxt_tst  = PBT_TURN;
        end
      default:
        nxt_tst = PBT_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tst_ff  <= PBT_IDLE;
      twr_ff  <= 1'b0;
      tw_ff   <= 2'h0;
      tidx_ff <= 4'h0;
      dsel_ff <= 1'b0;
    end
    else
    begin
      tst_ff  <= nxt_tst;
      twr_ff  <= nxt_twr;
      tw_ff   <= nxt_tw;
      tidx_ff <= nxt_tidx;
      dsel_ff <= nxt_dsel;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < MREG_N; gi++)
    begin : g_mreg
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
          mreg_ff[gi] <= 32'h0;
        else if (tst_ff == PBT_DATA && irdy_s && twr_ff && tidx_ff == MREG_IW'(gi))
          mreg_ff[gi] <= ad2_ff;
      end
    end
  endgenerate
  logic t_drv;
  logic t_rd;
  assign t_drv = rst_out_ff && !suspend_i && dsel_ff;
  assign t_rd  = t_drv && !twr_ff;
  assign bus.devsel_dev_oe_n = !t_drv;
  assign bus.devsel_n_dev_o  = 1'b0;
  assign bus.trdy_dev_oe_n   = !t_drv;
  assign bus.trdy_n_dev_o    = !(tst_ff == PBT_DATA);
  assign bus.ad_dev_oe_n     = !(i_adrv || t_rd);
  assign bus.ad_dev_o        = t_rd ? mreg_ff[tidx_ff] : iad_ff;
  assign bus.cbe_dev_oe_n    = !i_drv;
  assign bus.cbe_n_dev_o     = icb_ff;
  pbi_par_gen u_par (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .ad_i       (bus.ad_dev_o),
    .cbe_n_i    (t_rd ? bus.cbe_n : icb_ff),
    .drive_i    (i_adrv || t_rd),
    .par_o      (bus.par_dev_o),
    .par_oe_n_o (bus.par_dev_oe_n)
  );
endmodule
`default_nettype wire

// file: core/pbi_far_end.sv
// far agent end: simple initiator and always-ready target model in logic
`timescale 1ns/100ps
`default_nettype none
module pbi_far_end
  import pbi_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  pbi_bus_if.far           bus,
  input  wire logic        keep_clk_i,
  input  wire logic        cfg_sel_i,
  input  wire logic        req_valid_i,
  output logic             req_ready_o,
  input  wire logic [31:0] req_addr_i,
  input  wire logic [3:0]  req_cmd_i,
  input  wire logic [31:0] req_wdata_i,
  input  wire logic        claim_en_i,
  output logic             rsp_valid_o,
  output logic [31:0]      rsp_rdata_o
);
  pbi_ist_t    st_ff, nxt_st;
  logic [31:0] ad_ff, nxt_ad;
  logic [3:0]  cb_ff, nxt_cb;
  logic        rv_ff, nxt_rv;
  logic [31:0] rd_ff, nxt_rd;
  logic        dv_ff, nxt_dv;
  logic        wr;
  assign wr = req_cmd_i[0];
  always_comb
  begin
    nxt_st = st_ff;
    nxt_ad = ad_ff;
    nxt_cb = cb_ff;
    nxt_rv = 1'b0;
    nxt_rd = rd_ff;
    nxt_dv = 1'b0;
    case (st_ff)
      PBI_IDLE:
        if (req_valid_i && bus.frame_n && bus.bus_reset_out_n)
        begin
          nxt_ad = req_addr_i;
          nxt_cb = req_cmd_i;
          nxt_st = PBI_ADDR;
        end
      PBI_ADDR:
      begin
        nxt_ad = wr ? req_wdata_i : ad_ff;
        nxt_cb = 4'h0;
        nxt_st = PBI_DATA;
      end
      PBI_DATA:
        if (!bus.trdy_n && !bus.irdy_n)
        begin
          nxt_rd = bus.ad;
          nxt_rv = 1'b1;
          nxt_st = PBI_TURN;
        end
      default:
        nxt_st = PBI_IDLE;
    endcase
    if (claim_en_i && !bus.frame_n && st_ff == PBI_IDLE)
      nxt_dv = 1'b1;
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= PBI_IDLE;
      ad_ff <= 32'h0;
      cb_ff <= 4'hf;
      rv_ff <= 1'b0;
      rd_ff <= 32'h0;
      dv_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      ad_ff <= nxt_ad;
      cb_ff <= nxt_cb;
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
      dv_ff <= nxt_dv;
    end
  end
  logic drv;
  assign drv = st_ff == PBI_ADDR || st_ff == PBI_DATA;
  assign req_ready_o        = st_ff == PBI_IDLE && bus.frame_n && bus.bus_reset_out_n;
  assign rsp_valid_o        = rv_ff;
  assign rsp_rdata_o        = rd_ff;
  assign bus.idsel          = cfg_sel_i && st_ff == PBI_ADDR;
  assign bus.frame_far_oe_n = !drv;
  assign bus.frame_n_far_o  = !(st_ff == PBI_ADDR);
  assign bus.irdy_far_oe_n  = !(st_ff == PBI_DATA);
  assign bus.irdy_n_far_o   = 1'b0;
  assign bus.ad_far_oe_n    = !(st_ff == PBI_ADDR || (st_ff == PBI_DATA && wr)) && !dv_ff;
  assign bus.ad_far_o       = ad_ff;
  assign bus.cbe_far_oe_n   = !drv;
  assign bus.cbe_n_far_o    = cb_ff;
  assign bus.devsel_far_oe_n = !dv_ff;
  assign bus.devsel_n_far_o = 1'b0;
  assign bus.trdy_far_oe_n  = !dv_ff;
  assign bus.trdy_n_far_o   = 1'b0;
  assign bus.clkrun_far_oe_n = !keep_clk_i;
  assign bus.clkrun_n_far_o = 1'b0;
endmodule
`default_nettype wire

// file: tb/pbi_bus_monitor.sv
// concurrent checks on the shared bus wires
`timescale 1ns/100ps
`default_nettype none
module pbi_bus_monitor
  import pbi_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [31:0] ad,
  input wire logic [3:0]  cbe_n,
  input wire logic        frame_n,
  input wire logic        trdy_n,
  input wire logic        idsel,
  input wire logic        bus_reset_out_n,
  input wire logic        ad_dev_oe_n,
  input wire logic        cbe_dev_oe_n,
  input wire logic        frame_n_dev_o,
  input wire logic        frame_dev_oe_n,
  input wire logic        frame_far_oe_n,
  input wire logic        irdy_n_dev_o,
  input wire logic        irdy_dev_oe_n,
  input wire logic        devsel_n_dev_o,
  input wire logic        devsel_dev_oe_n,
  input wire logic        par_dev_o,
  input wire logic        par_dev_oe_n,
  input wire logic        clkrun_n_dev_o,
  input wire logic        clkrun_dev_oe_n
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ====================================
  // assertions
  property p_rst_float;
    disable iff (1'b0) rst |-> &{ad_dev_oe_n, cbe_dev_oe_n, frame_dev_oe_n, irdy_dev_oe_n};
  endproperty
  a_rst_float: assert property (p_rst_float) else $error("bus lanes driven in reset");
  property p_rst_clkrun;
    disable iff (1'b0) rst |-> !clkrun_dev_oe_n && !clkrun_n_dev_o;
  endproperty
  a_rst_clkrun: assert property (p_rst_clkrun) else $error("clock run not low in reset");
  property p_devsel_rst;
    disable iff (1'b0) !bus_reset_out_n |-> devsel_dev_oe_n;
  endproperty
  a_devsel_rst: assert property (p_devsel_rst) else $error("devsel driven in reset");
  property p_after_rst;
    $rose(bus_reset_out_n) |-> frame_dev_oe_n && ad_dev_oe_n && devsel_dev_oe_n;
  endproperty
  a_after_rst: assert property (p_after_rst) else $error("lanes driven at release");
  property p_addr_low;
    !frame_dev_oe_n && !frame_n_dev_o |-> !ad_dev_oe_n && ad[1:0] == ADDR_LOW_Z;
  endproperty
  a_addr_low: assert property (p_addr_low) else $error("address low bits not zero");
  property p_frame_one;
    !frame_dev_oe_n && !frame_n_dev_o |=> frame_n;
  endproperty
  a_frame_one: assert property (p_frame_one) else $error("frame not negated");
  property p_frame_own;
    !frame_far_oe_n |-> frame_dev_oe_n;
  endproperty
  a_frame_own: assert property (p_frame_own) else $error("frame driven as target");
  property p_par;
    !par_dev_oe_n |-> par_dev_o == ^{$past(ad), $past(cbe_n)};
  endproperty
  a_par: assert property (p_par) else $error("parity wrong");
  property p_cfg_claim;
    $fell(frame_n) && frame_dev_oe_n && idsel && (cbe_n == CMD_CFG_RD || cbe_n == CMD_CFG_WR)
      |-> ##[1:6] (!devsel_dev_oe_n && !devsel_n_dev_o);
  endproperty
  a_cfg_claim: assert property (p_cfg_claim) else $error("config cycle unclaimed");
  property p_reg_claim;
    $fell(frame_n) && frame_dev_oe_n && (ad & REG_MASK) == REG_BASE
      |-> ##[1:6] (!devsel_dev_oe_n && !devsel_n_dev_o);
  endproperty
  a_reg_claim: assert property (p_reg_claim) else $error("register hit unclaimed");
  property p_irdy_done;
    !irdy_dev_oe_n && !irdy_n_dev_o && !trdy_n |-> ##[1:5] (irdy_dev_oe_n || irdy_n_dev_o);
  endproperty
  a_irdy_done: assert property (p_irdy_done) else $error("data phase not done");
  c_dev_done: cover property (!irdy_dev_oe_n && !irdy_n_dev_o && !trdy_n);
  c_cfg: cover property ($fell(frame_n) && idsel);
  c_par: cover property (!par_dev_oe_n);
endmodule
`default_nettype wire

// file: tb/tb_pci_bus_side_interface.sv
// self-checking bench joining device end and far agent end
`timescale 1ns/100ps
`default_nettype none
module tb_pci_bus_side_interface;
  import pbi_pkg::*;
  logic        clk_sys, rst, suspend, stop_req, stop_ok, sub_en, keep_clk, cfg_sel, claim_en;
  logic        d_valid, d_ready, d_rv, d_abort, f_valid, f_ready, f_rv, seen_claim, prev_frame;
  logic [31:0] d_addr, d_wdata, d_rdata, f_addr, f_wdata, f_rdata, cap_addr, cap_data, rng, a, w;
  logic [3:0]  d_cmd, d_be, f_cmd, cap_cmd, cap_be;
  logic [3:0]  cmds [6] = '{CMD_IO_RD, CMD_IO_WR, CMD_MEM_RD, CMD_MEM_WR, CMD_CFG_RD, CMD_CFG_WR};
  int          miscompares;
  int          checked;
  // ====================================
  // instances
  pbi_bus_if bus ();
  pbi_dev_end pbi_dev_end_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus), .suspend_i(suspend),
    .clk_stop_req_i(stop_req), .clk_stop_ok_o(stop_ok), .subtractive_en_i(sub_en),
    .req_valid_i(d_valid), .req_ready_o(d_ready), .req_addr_i(d_addr), .req_cmd_i(d_cmd),
    .req_wdata_i(d_wdata), .req_be_i(d_be), .rsp_valid_o(d_rv), .rsp_rdata_o(d_rdata),
    .rsp_abort_o(d_abort));
  pbi_far_end pbi_far_end_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus), .keep_clk_i(keep_clk),
    .cfg_sel_i(cfg_sel), .req_valid_i(f_valid), .req_ready_o(f_ready), .req_addr_i(f_addr),
    .req_cmd_i(f_cmd), .req_wdata_i(f_wdata), .claim_en_i(claim_en), .rsp_valid_o(f_rv),
    .rsp_rdata_o(f_rdata));
  pbi_bus_monitor pbi_bus_monitor_inst (.clk_sys(clk_sys), .rst(rst), .ad(bus.ad),
    .cbe_n(bus.cbe_n), .frame_n(bus.frame_n), .trdy_n(bus.trdy_n), .idsel(bus.idsel),
    .bus_reset_out_n(bus.bus_reset_out_n), .ad_dev_oe_n(bus.ad_dev_oe_n),
    .cbe_dev_oe_n(bus.cbe_dev_oe_n), .frame_n_dev_o(bus.frame_n_dev_o),
    .frame_dev_oe_n(bus.frame_dev_oe_n), .frame_far_oe_n(bus.frame_far_oe_n),
    .irdy_n_dev_o(bus.irdy_n_dev_o), .irdy_dev_oe_n(bus.irdy_dev_oe_n),
    .devsel_n_dev_o(bus.devsel_n_dev_o), .devsel_dev_oe_n(bus.devsel_dev_oe_n),
    .par_dev_o(bus.par_dev_o), .par_dev_oe_n(bus.par_dev_oe_n),
    .clkrun_n_dev_o(bus.clkrun_n_dev_o), .clkrun_dev_oe_n(bus.clkrun_dev_oe_n));
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // wire capture of address and completed data phases
  always @(posedge clk_sys)
  begin
    if (prev_frame && !bus.frame_n)
    begin
      cap_addr = bus.ad;
      cap_cmd = bus.cbe_n;
    end
    if (!bus.irdy_n && !bus.trdy_n)
    begin
      cap_data = bus.ad;
      cap_be = bus.cbe_n;
    end
    if (!bus.devsel_dev_oe_n && !bus.devsel_n_dev_o)
      seen_claim = 1'b1;
    prev_frame = bus.frame_n;
  end
  // ====================================
  // tasks
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [31:0] floated();
    return {31'h0, &{bus.ad_dev_oe_n, bus.cbe_dev_oe_n, bus.frame_dev_oe_n,
                     bus.devsel_dev_oe_n, bus.par_dev_oe_n}};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      miscompares++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic xfer(input logic far, input logic [31:0] ad, input logic [3:0] c,
                      input logic [31:0] wd, input logic [3:0] be);
    int n;
    n = 0;
    d_addr = ad;
    f_addr = ad;
    d_cmd = c;
    f_cmd = c;
    d_wdata = wd;
    f_wdata = wd;
    d_be = be;
    d_valid = !far;
    f_valid = far;
    while (!(far ? f_ready : d_ready) && n < 40)
    begin
      tick(1);
      n++;
    end
    tick(1);
    d_valid = 1'b0;
    f_valid = 1'b0;
    while (!(far ? f_rv : d_rv) && n < 80)
    begin
      tick(1);
      n++;
    end
    chk("response", 32'h1, {31'h0, far ? f_rv : d_rv});
  endtask
  task automatic claim_case(input logic [31:0] ad, input logic [3:0] c, input logic sel, sb);
    cfg_sel = sel;
    sub_en = sb;
    seen_claim = 1'b0;
    xfer(1'b1, ad, c, 32'h0, 4'hf);
    chk("claim", 32'h1, {31'h0, seen_claim});
    cfg_sel = 1'b0;
    sub_en = 1'b0;
  endtask
  task automatic give_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    give_verdict();
  end
  // ====================================
  // sequence
  initial
  begin
    {rst, claim_en} = 2'h3;
    {suspend, stop_req, sub_en, keep_clk, cfg_sel, d_valid, f_valid, seen_claim} = 8'h0;
    {d_addr, d_wdata, f_addr, f_wdata, d_cmd, d_be, f_cmd} = 140'h0;
    {prev_frame, miscompares, checked, rng} = {1'b1, 64'h0, 32'h1291};
    tick(10);
    chk("float in reset", 32'h1, floated());
    chk("clock run in reset", 32'h0, {31'h0, bus.clkrun_n});
    rst = 1'b0;
    tick(1);
    chk("float after reset", 32'h1, floated());
    chk("reset out", 32'h1, {31'h0, bus.bus_reset_out_n});
    tick(1);
    for (int i = 0; i < 6; i++)
    begin
      rng = xs(rng);
      a = {rng[31:17], 1'b1, rng[15:0]};
      rng = xs(rng);
      w = rng;
      xfer(1'b0, a, cmds[i], w, w[7:4]);
      chk("address phase", {a[31:2], 2'h0}, cap_addr);
      chk("command", {28'h0, cmds[i]}, {28'h0, cap_cmd});
      chk("byte enables", {28'h0, ~w[7:4]}, {28'h0, cap_be});
      chk("no abort", 32'h0, {31'h0, d_abort});
      if (cmds[i][0])
        chk("write data", w, cap_data);
      else
        chk("read data", cap_data, d_rdata);
    end
    claim_en = 1'b0;
    xfer(1'b0, 32'h0004_0010, CMD_MEM_RD, 32'h0, 4'hf);
    chk("abort", 32'h1, {31'h0, d_abort});
    claim_en = 1'b1;
    for (int k = 0; k < 16; k += 15)
    begin
      rng = xs(rng);
      w = rng;
      xfer(1'b1, REG_BASE + 32'(k * 4), CMD_IO_WR, w, 4'hf);
      xfer(1'b1, REG_BASE + 32'(k * 4), CMD_IO_RD, 32'h0, 4'hf);
      chk("register readback", w, f_rdata);
    end
    claim_case(32'h0001_0000, CMD_CFG_RD, 1'b1, 1'b0);
    claim_case(32'h0000_0ffc, CMD_IO_WR, 1'b0, 1'b0);
    claim_case(32'h0002_0000, CMD_MEM_RD, 1'b0, 1'b1);
    {keep_clk, stop_req} = 2'h3;
    tick(4);
    chk("clock run held", 32'h0, {31'h0, bus.clkrun_n});
    chk("stop refused", 32'h0, {31'h0, stop_ok});
    keep_clk = 1'b0;
    tick(4);
    chk("stop granted", 32'h1, {31'h0, stop_ok});
    stop_req = 1'b0;
    suspend = 1'b1;
    tick(3);
    chk("float in suspend", 32'h1, floated());
    chk("clock run in suspend", 32'h1, {30'h0, bus.clkrun_dev_oe_n, bus.clkrun_n_dev_o});
    suspend = 1'b0;
    tick(2);
    rst = 1'b1;
    tick(2);
    chk("float in second reset", 32'h1, floated());
    chk("devsel in reset", 32'h1, {31'h0, bus.devsel_dev_oe_n});
    rst = 1'b0;
    tick(3);
    give_verdict();
  end
endmodule
`default_nettype wire
